// File: verilog/acr_control.sv
/*
 * converter control and status registers with conversion sequencer.
 * assumes a plain strobe bus, an analog core reached through the
 * result input, and trigger flags synchronous to core_clk.
 */
// Our own choices: the register offsets and the address-and-strobe port.
`timescale 1ns/1ps
`include "acr_defs.svh"

// Notes on behaviour
// - reference code 00 pin, 01 supply, 11 internal
// - reference and channel latch at conversion start
// - left_justify changes result presentation immediately
// - codes 0-7 single ended, 1E bandgap, 1F ground
// - channel code also sets 10x or 200x gain
// - codes 10-1D unity gain differential pairs
// - enable off aborts any running conversion
// - first conversion 25 cycles, later ones 13
// - start reads one while busy, zero write ignored
// - auto trigger starts on selected source rising edge
// - done flag sets when result is updated
// - interrupt request when done, enable, global enable
// - done clears on vector or written one
// - divider codes give 2 through 128
// - right justified: high byte holds bits 9:8
// - low byte read locks result until high read
// - left justified: high byte holds bits 9:2
// - trigger source codes map to eight sources
// - source switch can trigger, free running cannot
module acr_control
	import acr_pkg::*;
(
	// clock and reset
	input wire logic core_clk,
	input wire logic rst_b,
	// register bus
	input wire logic [3:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	// processor side
	input wire logic global_irq_enable,
	input wire logic irq_vector_taken,
	output logic done_irq,
	// trigger sources, codes 1 to 7
	input wire logic [7:1] trigger_flags,
	// analog core
	input wire logic [9:0] conversion_value,
	output logic converter_power,
	output logic sample_hold,
	output acr_mux_t active_mux,
	output logic [1:0] reference_code,
	output logic [3:0] positive_input,
	output logic [3:0] negative_input,
	output logic [1:0] gain_code
);

	// =============================================================
	// state
	logic [7:0] input_select_q, input_select_d;
	logic [7:0] ctrl_q, ctrl_d;
	logic [2:0] trigger_source_select_q, trigger_source_select_d;
	logic [9:0] result_q, result_d;
	logic lock_q, lock_d;
	logic first_q, first_d;
	logic trig_q, trig_d;
	logic done_prev_q, done_prev_d;
	logic [4:0] cyc_q, cyc_d;
	acr_state_t state_q, state_d;
	acr_mux_t mux_q, mux_d;
	logic [7:0] rdata_q, rdata_d;
	logic tick;
	logic trig_now;
	logic start_req;
	logic enable_w;
	logic [4:0] total;
	logic [15:0] shown;

	// presents the result in the selected justification
	function automatic logic [15:0] justify(input logic [9:0] r,
		input logic left);
		if (left)
			justify = {r, 6'h00};
		else
			justify = {6'h00, r};
	endfunction

	// =============================================================
	// prescaler
	acr_prescaler u_div (
		.core_clk(core_clk),
		.rst_b(rst_b),
		.run(ctrl_q[`ACR_BIT_ENABLE]),
		.clock_divider_select(ctrl_q[2:0]),
		.tick(tick)
	);

	// selected trigger level, held at zero under the free running code
	always_comb
	begin
		trig_now = 1'b0;
		if (trigger_source_select_q != 3'h0)
			trig_now = trigger_flags[trigger_source_select_q];
	end

	// register writes, trigger detection and sequencing
	always_comb
	begin
		input_select_d = input_select_q;
		ctrl_d = ctrl_q;
		trigger_source_select_d = trigger_source_select_q;
		result_d = result_q;
		lock_d = lock_q;
		first_d = first_q;
		trig_d = trig_now;
		done_prev_d = ctrl_q[`ACR_BIT_DONE];
		cyc_d = cyc_q;
		state_d = state_q;
		mux_d = mux_q;
		start_req = 1'b0;
		enable_w = ctrl_q[`ACR_BIT_ENABLE];
		total = first_q ? `ACR_FIRST_CYCLES : `ACR_NORMAL_CYCLES;
		if (reg_wr && reg_addr == `ACR_OFF_INPUT_SELECT)
			input_select_d = reg_wdata;
		if (reg_wr && reg_addr == `ACR_OFF_CTRL_B)
			trigger_source_select_d = reg_wdata[2:0];
		if (reg_wr && reg_addr == `ACR_OFF_CTRL_STATUS)
		begin
			enable_w = reg_wdata[`ACR_BIT_ENABLE];
			ctrl_d[`ACR_BIT_ENABLE] = enable_w;
			ctrl_d[`ACR_BIT_AUTO] = reg_wdata[`ACR_BIT_AUTO];
			ctrl_d[`ACR_BIT_IRQ_EN] = reg_wdata[`ACR_BIT_IRQ_EN];
			ctrl_d[2:0] = reg_wdata[2:0];
			if (reg_wdata[`ACR_BIT_DONE])
				ctrl_d[`ACR_BIT_DONE] = 1'b0;
			if (reg_wdata[`ACR_BIT_START])
				start_req = 1'b1;
			if (enable_w && !ctrl_q[`ACR_BIT_ENABLE])
				first_d = 1'b1;
		end
		if (irq_vector_taken)
			ctrl_d[`ACR_BIT_DONE] = 1'b0;
		// auto trigger: rising edge of source, or of done flag
		if (ctrl_q[`ACR_BIT_AUTO])
		begin
			if (trigger_source_select_q == 3'h0)
			begin
				if (ctrl_q[`ACR_BIT_DONE] && !done_prev_q)
					start_req = 1'b1;
			end
			else if (trig_now && !trig_q)
				start_req = 1'b1;
		end
		if (reg_rd && reg_addr == `ACR_OFF_RESULT_LOW)
			lock_d = 1'b1;
		if (reg_rd && reg_addr == `ACR_OFF_RESULT_HIGH)
			lock_d = 1'b0;
		unique case (state_q)
			ACR_IDLE:
				if (start_req && enable_w)
				begin
					mux_d = '{input_select_q[7:6], input_select_q[4:0]};
					ctrl_d[`ACR_BIT_START] = 1'b1;
					cyc_d = 5'h00;
					state_d = ACR_CONVERT;
				end
			ACR_CONVERT:
				if (tick)
				begin
					cyc_d = cyc_q + 5'h01;
					if (cyc_q + 5'h01 == total)
						state_d = ACR_FINISH;
				end
			ACR_FINISH:
				// result waits while the low byte lock is held
				if (!lock_d)
				begin
					result_d = conversion_value;
					ctrl_d[`ACR_BIT_DONE] = 1'b1;
					ctrl_d[`ACR_BIT_START] = 1'b0;
					first_d = 1'b0;
					state_d = ACR_IDLE;
				end
		endcase
		if (!enable_w)
		begin
			state_d = ACR_IDLE;
			ctrl_d[`ACR_BIT_START] = 1'b0;
		end
	end

	// registered read data, one cycle after the strobe
	always_comb
	begin
		rdata_d = 8'h00;
		shown = justify(result_q, input_select_q[`ACR_BIT_LEFT]);
		if (reg_rd)
		begin
			unique case (reg_addr)
				`ACR_OFF_INPUT_SELECT: rdata_d = input_select_q;
				`ACR_OFF_CTRL_STATUS: rdata_d = ctrl_q;
				`ACR_OFF_RESULT_LOW: rdata_d = shown[7:0];
				`ACR_OFF_RESULT_HIGH: rdata_d = shown[15:8];
				`ACR_OFF_CTRL_B: rdata_d = {5'h00, trigger_source_select_q};
				default: rdata_d = 8'h00;
			endcase
		end
	end

	// all registers
	always_ff @(posedge core_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			input_select_q <= `ACR_RESET_BYTE;
			ctrl_q <= `ACR_RESET_BYTE;
			trigger_source_select_q <= 3'h0;
			result_q <= 10'h000;
			lock_q <= 1'b0;
			first_q <= 1'b1;
			trig_q <= 1'b0;
			done_prev_q <= 1'b0;
			cyc_q <= 5'h00;
			state_q <= ACR_IDLE;
			mux_q <= '0;
			rdata_q <= 8'h00;
		end
		else
		begin
			input_select_q <= input_select_d;
			ctrl_q <= ctrl_d;
			trigger_source_select_q <= trigger_source_select_d;
			result_q <= result_d;
			lock_q <= lock_d;
			first_q <= first_d;
			trig_q <= trig_d;
			done_prev_q <= done_prev_d;
			cyc_q <= cyc_d;
			state_q <= state_d;
			mux_q <= mux_d;
			rdata_q <= rdata_d;
		end
	end

	// analog routing from the latched channel code
	always_comb
	begin
		positive_input = 4'h0;
		negative_input = 4'h0;
		gain_code = 2'h0; // 0 single, 1 unity, 2 10x, 3 200x
		if (mux_q.channel_select[4:3] == 2'h0)
			positive_input = {1'b0, mux_q.channel_select[2:0]};
		else if (mux_q.channel_select[4:3] == 2'h1)
		begin
			positive_input = {3'h0, mux_q.channel_select[0]} +
				{2'h0, mux_q.channel_select[2], 1'b0};
			negative_input = {2'h0, mux_q.channel_select[2], 1'b0};
			gain_code = mux_q.channel_select[1] ? 2'h3 : 2'h2;
		end
		else if (mux_q.channel_select >= 5'h1E)
			positive_input = mux_q.channel_select[0] ? 4'hF : 4'hE;
		else
		begin
			positive_input = {1'b0, mux_q.channel_select[2:0]};
			negative_input = mux_q.channel_select[3] ? 4'h2 : 4'h1;
			gain_code = 2'h1;
		end
	end

	// outputs
	assign reg_rdata = rdata_q;
	assign reference_code = mux_q.reference_select;
	assign active_mux = mux_q;
	assign converter_power = ctrl_q[`ACR_BIT_ENABLE];
	assign sample_hold = (state_q == ACR_CONVERT);
	assign done_irq = ctrl_q[`ACR_BIT_DONE] && ctrl_q[`ACR_BIT_IRQ_EN] &&
		global_irq_enable;

	// =============================================================
	// checks
	sequence s_off_write;
		reg_wr && reg_addr == `ACR_OFF_CTRL_STATUS &&
			!reg_wdata[`ACR_BIT_ENABLE];
	endsequence

	AST_ABORT: assert property (@(posedge core_clk) disable iff (!rst_b)
		s_off_write |=> state_q == ACR_IDLE && !ctrl_q[`ACR_BIT_START])
		else $error("conversion not aborted on disable");
	AST_START_BUSY: assert property (@(posedge core_clk) disable iff (!rst_b)
		ctrl_q[`ACR_BIT_START] == (state_q != ACR_IDLE))
		else $error("start bit disagrees with sequencer");
	AST_DONE_SET: assert property (@(posedge core_clk) disable iff (!rst_b)
		state_q == ACR_FINISH && state_d == ACR_IDLE && enable_w |=>
		ctrl_q[`ACR_BIT_DONE] && result_q == $past(conversion_value))
		else $error("done flag or result missing");
	AST_IRQ: assert property (@(posedge core_clk) disable iff (!rst_b)
		done_irq == (ctrl_q[4] && ctrl_q[3] && global_irq_enable))
		else $error("interrupt request wrong");
	AST_VEC_CLR: assert property (@(posedge core_clk) disable iff (!rst_b)
		irq_vector_taken && state_q != ACR_FINISH |=> !ctrl_q[4])
		else $error("done flag not cleared by vector");
	AST_MUX_HOLD: assert property (@(posedge core_clk) disable iff (!rst_b)
		state_q == ACR_CONVERT && $past(state_q) == ACR_CONVERT |->
		$stable(mux_q))
		else $error("mux changed during conversion");
	AST_LOCK: assert property (@(posedge core_clk) disable iff (!rst_b)
		lock_q && !(reg_rd && reg_addr == `ACR_OFF_RESULT_HIGH) |=>
		$stable(result_q))
		else $error("result changed while locked");
	AST_LENGTH: assert property (@(posedge core_clk) disable iff (!rst_b)
		state_q == ACR_FINISH && $past(state_q) == ACR_CONVERT |->
		$past(cyc_q) + 5'h01 == (first_q ? 5'h19 : 5'h0D))
		else $error("conversion length wrong");

endmodule

// File: verilog/acr_defs.svh
/*
 * offsets, field positions, reset values and timing counts of the
 * converter control block.
 * assumes inclusion by bare name from the control and prescaler modules.
 */
`ifndef ACR_DEFS_SVH
`define ACR_DEFS_SVH

// =============================================================
// register offsets
`define ACR_OFF_INPUT_SELECT 4'h0
`define ACR_OFF_CTRL_STATUS 4'h1
`define ACR_OFF_RESULT_LOW 4'h2
`define ACR_OFF_RESULT_HIGH 4'h3
`define ACR_OFF_CTRL_B 4'h4

// =============================================================
// field positions
`define ACR_BIT_ENABLE 7
`define ACR_BIT_START 6
`define ACR_BIT_AUTO 5
`define ACR_BIT_DONE 4
`define ACR_BIT_IRQ_EN 3
`define ACR_BIT_LEFT 5

// =============================================================
// reset values and timing
`define ACR_RESET_BYTE 8'h00
`define ACR_FIRST_CYCLES 5'h19
`define ACR_NORMAL_CYCLES 5'h0D

`endif

// File: verilog/acr_pkg.sv
/*
 * types shared by the converter control block.
 * assumes acr_defs.svh sits on the include path.
 */
package acr_pkg;

	// =============================================================
	// conversion sequencer states
	typedef enum logic [1:0] {ACR_IDLE, ACR_CONVERT, ACR_FINISH} acr_state_t;

	// analog front end settings held for one conversion
	typedef struct packed {
		logic [1:0] reference_select;
		logic [4:0] channel_select;
	} acr_mux_t;

	// register bus request
	typedef struct packed {
		logic [3:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} acr_bus_t;

endpackage

// File: verilog/acr_prescaler.sv
/*
 * prescaler forming the one-cycle converter clock enable.
 * assumes one system clock; restarts whenever the converter is off.
 */
`timescale 1ns/1ps
`include "acr_defs.svh"

module acr_prescaler
	import acr_pkg::*;
(
	// clock and reset
	input wire logic core_clk,
	input wire logic rst_b,
	// control
	input wire logic run,
	input wire logic [2:0] clock_divider_select,
	// enable out
	output logic tick
);

	logic [6:0] cnt_q;
	logic [6:0] cnt_d;
	logic [6:0] last;

	// terminal count per divider code, 000 and 001 both divide by 2
	always_comb
	begin
		unique case (clock_divider_select)
			3'h0, 3'h1: last = 7'h01;
			3'h2: last = 7'h03;
			3'h3: last = 7'h07;
			3'h4: last = 7'h0F;
			3'h5: last = 7'h1F;
			3'h6: last = 7'h3F;
			3'h7: last = 7'h7F;
		endcase
	end

	// count only while enabled, restart from zero when off
	always_comb
	begin
		cnt_d = cnt_q;
		tick = 1'b0;
		if (!run)
			cnt_d = 7'h00;
		else if (cnt_q >= last)
		begin
			cnt_d = 7'h00;
			tick = 1'b1;
		end
		else
			cnt_d = cnt_q + 7'h01;
	end

	// counter register
	always_ff @(posedge core_clk or negedge rst_b)
	begin
		if (!rst_b)
			cnt_q <= 7'h00;
		else
			cnt_q <= cnt_d;
	end

	AST_DIV_HALTED: assert property (@(posedge core_clk) disable iff (!rst_b)
		!run |=> cnt_q == 7'h00)
		else $error("prescaler counted while converter off");

endmodule

// File: dv/acr_control_test.sv
/*
 * self-checking bench of the converter control block.
 * assumes acr_pkg compiled first and acr_defs.svh on the include path.
 */
`timescale 1ns/1ps

module acr_control_test
	import acr_pkg::*;
;
	// =============================================================
	// signals
	logic core_clk = 1'b0;
	logic rst_b = 1'b0;
	logic [3:0] reg_addr = 4'h0;
	logic [7:0] reg_wdata = 8'h00;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [7:0] reg_rdata;
	logic global_irq_enable = 1'b0;
	logic irq_vector_taken = 1'b0;
	logic done_irq;
	logic [7:1] trigger_flags = 7'h00;
	logic [9:0] conversion_value = 10'h000;
	logic converter_power, sample_hold;
	acr_mux_t active_mux;
	logic [1:0] reference_code, gain_code;
	logic [3:0] positive_input, negative_input;
	logic [7:0] exp_q[$];
	logic rd_seen = 1'b0;
	int err_count = 0;
	int samples_checked = 0;
	int cycles = 0;
	int i, n, div;
	logic [9:0] v, w;
	logic [7:0] r;
	logic [4:0] codes [10] = '{5'h03, 5'h09, 5'h0B, 5'h0D, 5'h0F,
		5'h10, 5'h11, 5'h1D, 5'h1E, 5'h1F};
	// expected {positive, negative, gain} per code
	logic [9:0] decs [10] = '{10'h0C0, 10'h042, 10'h043, 10'h0CA,
		10'h0CB, 10'h005, 10'h045, 10'h149, 10'h380, 10'h3C0};

	acr_control i_acr_control (.core_clk, .rst_b, .reg_addr, .reg_wdata,
		.reg_wr, .reg_rd, .reg_rdata, .global_irq_enable,
		.irq_vector_taken, .done_irq, .trigger_flags, .conversion_value,
		.converter_power, .sample_hold, .active_mux, .reference_code,
		.positive_input, .negative_input, .gain_code);

	// =============================================================
	// clock, ceiling and read monitor
	always #25 core_clk = ~core_clk;

	// cycle ceiling against hangs
	always @(posedge core_clk)
	begin
		cycles <= cycles + 1;
		if (cycles == 20000)
		begin
			err_count++;
			results();
		end
	end

	// read answer stands in the cycle after the strobe
	always @(posedge core_clk) rd_seen <= reg_rd;
	always @(negedge core_clk)
		if (rd_seen === 1'b1)
			check("read data", reg_rdata, exp_q.pop_front());

	// =============================================================
	// tasks
	task check(input string name, input logic [9:0] seen, exp);
		samples_checked++;
		if (seen !== exp)
		begin
			err_count++;
			$display("wrong value %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task results;
		$display("checked %0d mismatches %0d", samples_checked, err_count);
		if (err_count == 0 && samples_checked > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	task wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge core_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge core_clk);
		reg_wr <= 1'b0;
	endtask

	task rd(input logic [3:0] a, input logic [7:0] e);
		@(posedge core_clk);
		exp_q.push_back(e);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge core_clk);
		reg_rd <= 1'b0;
	endtask

	// wait until sample_hold shows lvl, bounded
	task wait_hold(input logic lvl, input int lim);
		n = 0;
		do
		begin
			@(negedge core_clk);
			n++;
		end while (sample_hold !== lvl && n < lim);
	endtask

	// start a conversion and time it in system cycles
	// divider runs free once enabled: first tick 1 to div cycles on
	task run_conv(input logic [7:0] ctrl, input int ticks);
		wr(4'h1, ctrl);
		wait_hold(1'b0, 5000);
		check("duration", n > (ticks - 1) * div + 1 &&
			n <= ticks * div + 1, 1'b1);
		repeat (3) @(negedge core_clk);
	endtask

	// =============================================================
	// tests
	initial
	begin
		void'($urandom(12));
		repeat (8) @(posedge core_clk);
		rst_b <= 1'b1;
		// reset values, unmapped place, plain access
		for (i = 0; i < 6; i++)
			rd(i[3:0], 8'h00);
		wr(4'h5, 8'hFF);
		rd(4'h5, 8'h00);
		r = 8'($urandom);
		wr(4'h0, r);
		rd(4'h0, r);
		wr(4'h0, 8'h00);
		$display("test registers done");
		// first conversion, then each divider code
		div = 2;
		run_conv(8'hC0, 25);
		rd(4'h1, 8'h90);
		for (i = 0; i < 8; i++)
		begin
			div = (i == 0) ? 2 : (1 << i);
			wr(4'h1, 8'h90 | i[7:0]);
			run_conv(8'hC0 | i[7:0], 13);
			rd(4'h1, 8'h90 | i[7:0]);
			wr(4'h1, 8'h90 | i[7:0]);
			rd(4'h1, 8'h80 | i[7:0]);
		end
		$display("test timing done");
		// result layouts and the read lock
		div = 2;
		v = 10'($urandom);
		conversion_value <= v;
		run_conv(8'hC0, 13);
		rd(4'h2, v[7:0]);
		rd(4'h3, {6'h00, v[9:8]});
		wr(4'h0, 8'h20);
		rd(4'h2, {v[1:0], 6'h00});
		w = ~v;
		conversion_value <= w;
		wr(4'h1, 8'hD0);
		repeat (40) @(posedge core_clk);
		rd(4'h3, v[9:2]);
		repeat (5) @(posedge core_clk);
		rd(4'h2, {w[1:0], 6'h00});
		rd(4'h3, w[9:2]);
		wr(4'h0, 8'h00);
		$display("test result done");
		// done interrupt
		wr(4'h1, 8'h90);
		run_conv(8'hC8, 13);
		check("irq gated", done_irq, 1'b0);
		@(posedge core_clk);
		global_irq_enable <= 1'b1;
		@(negedge core_clk);
		check("irq", done_irq, 1'b1);
		@(posedge core_clk);
		irq_vector_taken <= 1'b1;
		@(posedge core_clk);
		irq_vector_taken <= 1'b0;
		@(negedge core_clk);
		check("irq cleared", done_irq, 1'b0);
		rd(4'h1, 8'h88);
		$display("test interrupt done");
		// mux latch and decode
		for (i = 0; i < 10; i++)
		begin
			r = {i[1:0], 1'b0, codes[i]};
			wr(4'h0, r);
			wr(4'h1, 8'hC0);
			wr(4'h0, 8'h00);
			@(negedge core_clk);
			check("mux", active_mux, {r[7:6], r[4:0]});
			check("ref", reference_code, r[7:6]);
			check("pos", positive_input, decs[i][9:6]);
			check("gain", gain_code, decs[i][1:0]);
			if (decs[i][1:0] != 2'd0)
				check("neg", negative_input, decs[i][5:2]);
			wait_hold(1'b0, 5000);
			wr(4'h1, 8'h90);
		end
		$display("test mux done");
		// abort, refused start, re-enable
		wr(4'h1, 8'hC0);
		wr(4'h1, 8'h00);
		repeat (2) @(negedge core_clk);
		check("abort", sample_hold, 1'b0);
		check("power", converter_power, 1'b0);
		wr(4'h1, 8'h40);
		rd(4'h1, 8'h00);
		run_conv(8'hC0, 25);
		$display("test abort done");
		// each trigger source on its rising edge
		for (i = 1; i < 8; i++)
		begin
			@(posedge core_clk);
			trigger_flags <= ~(7'h01 << (i - 1));
			wr(4'h4, i[7:0]);
			wr(4'h1, 8'hB0);
			wait_hold(1'b1, 6);
			check("no trigger", sample_hold, 1'b0);
			@(posedge core_clk);
			trigger_flags <= 7'h7F;
			wait_hold(1'b1, 6);
			check("trigger", sample_hold, 1'b1);
			wait_hold(1'b0, 5000);
		end
		// source switch to a set flag, then to free running
		wr(4'h4, 8'h00);
		wr(4'h1, 8'hB0);
		wr(4'h4, 8'h03);
		wait_hold(1'b1, 6);
		check("switch", sample_hold, 1'b1);
		wait_hold(1'b0, 5000);
		wr(4'h4, 8'h00);
		wait_hold(1'b1, 8);
		check("free switch", sample_hold, 1'b0);
		wr(4'h1, 8'hF0);
		wait_hold(1'b0, 5000);
		wait_hold(1'b1, 8);
		check("free run", sample_hold, 1'b1);
		wr(4'h1, 8'h10);
		$display("test trigger done");
		results();
	end
endmodule
